/* File: inc/tof_result_pkg.sv */
package tof_result_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Bus geometry
	localparam int APB_ADDR_W = 8;
	localparam int APB_DATA_W = 32;
	localparam int WORD_W = 24;
	localparam int IDX_W = 6;

	////////////////////////////////////////////////////////////////////////////////
	// Register indices as printed, byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_FINE_SLOT3 = 6'h14;
	localparam logic [IDX_W-1:0] IDX_COARSE_SLOT3 = 6'h15;
	localparam logic [IDX_W-1:0] IDX_FINE_SLOT4 = 6'h16;
	localparam logic [IDX_W-1:0] IDX_COARSE_SLOT4 = 6'h17;
	localparam logic [IDX_W-1:0] IDX_FINE_SLOT5 = 6'h18;
	localparam logic [IDX_W-1:0] IDX_COARSE_SLOT5 = 6'h19;
	localparam logic [IDX_W-1:0] IDX_FIRST = IDX_FINE_SLOT3;
	localparam logic [IDX_W-1:0] IDX_LAST = IDX_COARSE_SLOT5;
	localparam logic [APB_ADDR_W-1:0] ADDR_FINE_SLOT3 = {IDX_FINE_SLOT3, 2'h0};
	localparam logic [APB_ADDR_W-1:0] ADDR_COARSE_SLOT3 = {IDX_COARSE_SLOT3, 2'h0};
	localparam logic [APB_ADDR_W-1:0] ADDR_FINE_SLOT4 = {IDX_FINE_SLOT4, 2'h0};
	localparam logic [APB_ADDR_W-1:0] ADDR_COARSE_SLOT4 = {IDX_COARSE_SLOT4, 2'h0};
	localparam logic [APB_ADDR_W-1:0] ADDR_FINE_SLOT5 = {IDX_FINE_SLOT5, 2'h0};
	localparam logic [APB_ADDR_W-1:0] ADDR_COARSE_SLOT5 = {IDX_COARSE_SLOT5, 2'h0};

	////////////////////////////////////////////////////////////////////////////////
	// Field layout of the result words
	localparam int PARITY_BIT = 23;
	localparam int FINE_W = 23;
	localparam int COARSE_W = 16;
	localparam int SPARE_W = 7;
	localparam logic [SPARE_W-1:0] SPARE_RESET = 7'h00;
	localparam logic [WORD_W-1:0] WORD_RESET = 24'h000000;
	localparam logic [APB_DATA_W-1:0] RDATA_IDLE = 32'h00000000;
	localparam logic [APB_DATA_W-WORD_W-1:0] RDATA_PAD = 8'h00;

	////////////////////////////////////////////////////////////////////////////////
	// Slots held by this bank
	localparam int SLOT_COUNT = 3;
	localparam int SLOT_W = 2;
	localparam logic [SLOT_W-1:0] SLOT_THREE = 2'h0;
	localparam logic [SLOT_W-1:0] SLOT_FIVE = 2'h2;
	localparam bit PARITY_ODD = 1'b0;

	////////////////////////////////////////////////////////////////////////////////
	// Bus answer sequencer
	typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_RESP} bus_state_t;

endpackage

/* File: rtl/result_parity.sv */
module result_parity #(
	parameter int DATA_W = 23,
	parameter bit ODD = 1'b0
) (
	// Data covered
	input wire logic [DATA_W-1:0] data_in,
	// Parity bit for the top of the word
	output logic parity_out
);

	// Reduction xor, inverted for odd parity
	assign parity_out = (^data_in) ^ ODD;

endmodule // result_parity

/* File: rtl/result_store.sv */
module result_store #(
	parameter int WIDTH = 48,
	parameter int DEPTH = 3,
	parameter int AW = 2
) (
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic rst_in,
	// Write port
	input wire logic wr_en_in,
	input wire logic [AW-1:0] wr_addr_in,
	input wire logic [WIDTH-1:0] wr_data_in,
	// Read port
	input wire logic rd_en_in,
	input wire logic [AW-1:0] rd_addr_in,
	output logic [WIDTH-1:0] rd_data_out
);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [WIDTH-1:0] rd_data_q;

	// Entries clear at reset, then take measurement updates
	always_ff @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			for (int i = 0; i < DEPTH; i++)
				mem_q[i] <= '0;
		end
		else if (wr_en_in)
			mem_q[wr_addr_in] <= wr_data_in;
	end

	// Registered read data
	always_ff @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
			rd_data_q <= '0;
		else if (rd_en_in)
			rd_data_q <= mem_q[rd_addr_in];
	end

	assign rd_data_out = rd_data_q;

endmodule // result_store

/* File: rtl/tof_result_readout_regs.sv */
// What this block does
// - The slot three fine word sits at index 14h with its 23-bit result low and parity in bit 23.
// - The slot three coarse word sits at index 15h with a 16-bit count low and parity in bit 23.
// - The slot four fine word sits at index 16h laid out like the other fine words.
// - The slot four coarse word sits at index 17h with its count low and parity on top.
// - The slot five fine word sits at index 18h with parity in bit 23 and the result below.
// - The slot five coarse word sits at index 19h laid out like the other coarse words.
// - Bits 22 to 16 of every coarse word read zero, kept spare for wider averaged counts.
// - Each fine field is an unsigned 23-bit value with its MSB at bit 22 and LSB at bit 0.
// - Every field including parity is read-only and reads zero from reset until updated.
module tof_result_readout_regs
#(
	parameter int SLOTS = tof_result_pkg::SLOT_COUNT
) (
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic rst_in,
	// Channel select from the host, active low
	input wire logic channel_select_n_in,
	// Measurement engine update
	input wire logic meas_valid_in,
	input wire logic [tof_result_pkg::SLOT_W-1:0] meas_slot_in,
	input wire logic [tof_result_pkg::FINE_W-1:0] meas_fine_in,
	input wire logic [tof_result_pkg::COARSE_W-1:0] meas_coarse_in,
	// APB slave
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [tof_result_pkg::APB_ADDR_W-1:0] paddr_in,
	input wire logic [tof_result_pkg::APB_DATA_W-1:0] pwdata_in,
	input wire logic [3:0] pstrb_in,
	output logic [tof_result_pkg::APB_DATA_W-1:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out
);

	import tof_result_pkg::*;

	localparam int ENTRY_W = 2 * WORD_W;

	////////////////////////////////////////////////////////////////////////////////
	// Update path: build both words of a slot with fresh parity

	logic [FINE_W-1:0] fine_body;
	logic [FINE_W-1:0] coarse_body;
	logic [1:0] parity_bits;
	logic [FINE_W-1:0] parity_src [2];
	logic [WORD_W-1:0] fine_word;
	logic [WORD_W-1:0] coarse_word;
	logic slot_ok;
	logic store_wr;

	// Fine field unsigned, bit 22 down to bit 0
	assign fine_body = meas_fine_in;
	// Spare bits forced to zero above the count
	assign coarse_body = {SPARE_RESET, meas_coarse_in};
	assign parity_src[0] = fine_body;
	assign parity_src[1] = coarse_body;

	// One parity generator per word of the slot
	for (genvar g = 0; g < 2; g++)
	begin : gen_parity
		result_parity #(
			.DATA_W(FINE_W),
			.ODD(PARITY_ODD)
		) u_parity (
			.data_in(parity_src[g]),
			.parity_out(parity_bits[g])
		);
	end

	// Parity on top of each word
	assign fine_word = {parity_bits[0], fine_body};
	assign coarse_word = {parity_bits[1], coarse_body};

	// Only slots three to five are held here
	assign slot_ok = meas_slot_in <= SLOT_FIVE;
	assign store_wr = meas_valid_in && slot_ok;

	////////////////////////////////////////////////////////////////////////////////
	// APB decode

	logic setup_phase;
	logic [IDX_W-1:0] word_idx;
	logic [IDX_W-1:0] word_off;
	logic addr_aligned;
	logic addr_hit;
	logic chan_sel;
	logic access_ok;
	logic [SLOT_W-1:0] rd_slot;
	logic rd_coarse;

	assign setup_phase = psel_in && !penable_in;
	assign word_idx = paddr_in[APB_ADDR_W-1:2];
	assign word_off = word_idx - IDX_FIRST;
	assign addr_aligned = paddr_in[1:0] == 2'h0;
	// Window of six words, index 14h to 19h
	assign addr_hit = addr_aligned && (word_idx >= IDX_FIRST) && (word_idx <= IDX_LAST);
	// Access counts only while this channel is selected
	assign chan_sel = !channel_select_n_in;
	assign access_ok = addr_hit && chan_sel;
	// Even index is the fine word, odd index the coarse word of the same slot
	assign rd_slot = word_off[SLOT_W:1];
	assign rd_coarse = word_off[0];

	////////////////////////////////////////////////////////////////////////////////
	// Result storage, reset to zero, no write from the bus

	logic [ENTRY_W-1:0] rd_entry;

	result_store #(
		.WIDTH(ENTRY_W),
		.DEPTH(SLOTS),
		.AW(SLOT_W)
	) u_store (
		.core_clk_in(core_clk_in),
		.rst_in(rst_in),
		.wr_en_in(store_wr),
		.wr_addr_in(meas_slot_in),
		.wr_data_in({coarse_word, fine_word}),
		.rd_en_in(setup_phase && addr_hit),
		.rd_addr_in(rd_slot),
		.rd_data_out(rd_entry)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Read data selection

	logic [WORD_W-1:0] rd_word;
	logic [APB_DATA_W-1:0] rd_bus;

	// Pick the fine or coarse half of the fetched entry
	assign rd_word = rd_coarse ? rd_entry[ENTRY_W-1:WORD_W] : rd_entry[WORD_W-1:0];
	// Upper byte reads zero; writes and misses return zero
	assign rd_bus = (access_ok && !pwrite_in) ? {RDATA_PAD, rd_word} : RDATA_IDLE;

	////////////////////////////////////////////////////////////////////////////////
	// Answer sequencer: fetch one cycle, answer the next

	bus_state_t state_q;
	bus_state_t state_d;
	logic [APB_DATA_W-1:0] prdata_q;
	logic [APB_DATA_W-1:0] prdata_d;
	logic pready_q;
	logic pready_d;
	logic pslverr_q;
	logic pslverr_d;

	// Next state and answer values
	always_comb
	begin
		state_d = state_q;
		prdata_d = prdata_q;
		pready_d = 1'b0;
		pslverr_d = 1'b0;
		case (state_q)
			ST_IDLE:
			begin
				prdata_d = RDATA_IDLE;
				if (setup_phase)
					state_d = ST_FETCH;
			end
			ST_FETCH:
			begin
				state_d = ST_RESP;
				prdata_d = rd_bus;
				pready_d = 1'b1;
				// Writes are dropped quietly, misses and deselected reads flag an error
				pslverr_d = !access_ok && !pwrite_in;
			end
			ST_RESP:
			begin
				state_d = ST_IDLE;
				prdata_d = RDATA_IDLE;
			end
			default:
			begin
				state_d = ST_IDLE;
				prdata_d = RDATA_IDLE;
			end
		endcase
	end

	// Sequencer state
	always_ff @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
			state_q <= ST_IDLE;
		else
			state_q <= state_d;
	end

	// Registered bus answer
	always_ff @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			prdata_q <= RDATA_IDLE;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end
		else
		begin
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	assign prdata_out = prdata_q;
	assign pready_out = pready_q;
	assign pslverr_out = pslverr_q;

	// Write data and strobes have no destination in a read-only bank
	logic unused_bus;
	assign unused_bus = ^{pwdata_in, pstrb_in};

endmodule // tof_result_readout_regs

/* File: test/tof_result_chk_properties.sv */
module tof_result_chk (
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic rst_in,
	// Bus and select at the pins
	input wire logic channel_select_n_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] prdata_out,
	input wire logic pready_out,
	input wire logic pslverr_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (rst_in);
	// Address outside the six aligned words
	wire bad_a = paddr_in[1:0] != 2'h0 || paddr_in < 8'h50 || paddr_in > 8'h64;
	AST_RDY_WAIT: assert property (psel_in && !penable_in |=> !pready_out ##1 pready_out)
		else $error("pready not on second access cycle");
	AST_RDY_ONE: assert property (pready_out |=> !pready_out)
		else $error("pready held too long");
	AST_ERR_READ: assert property (pready_out && !pwrite_in |->
		pslverr_out == ($past(channel_select_n_in) || bad_a))
		else $error("read error flag wrong");
	AST_WR_OKAY: assert property (pready_out && pwrite_in |-> !pslverr_out && prdata_out == 32'h0)
		else $error("write not silently dropped");
	AST_PAD: assert property (pready_out |-> prdata_out[31:24] == 8'h00)
		else $error("upper byte not zero");
	AST_SPARE: assert property (pready_out && paddr_in[2] |-> prdata_out[22:16] == 7'h00)
		else $error("spare count bits not zero");
	AST_PARITY: assert property (pready_out |-> !(^prdata_out[23:0]))
		else $error("parity bit wrong");
	AST_QUIET: assert property (!pready_out |-> prdata_out == 32'h0 && !pslverr_out)
		else $error("bus answer outside answer cycle");
	AST_ERR_DATA: assert property (pslverr_out |-> prdata_out == 32'h0)
		else $error("data with error");
	// Main scenarios
	COV_READ: cover property (pready_out && !pslverr_out && !pwrite_in);
	COV_ERR: cover property (pslverr_out);
	COV_WRITE: cover property (pready_out && pwrite_in);
endmodule // tof_result_chk

bind tof_result_readout_regs tof_result_chk chk_u (.*);

/* File: test/tof_host_model.sv */
module tof_host_model (
	// Clock
	input wire logic core_clk_in,
	// Answer from the device
	input wire logic pready_in,
	input wire logic pslverr_in,
	input wire logic [31:0] prdata_in,
	// Request to the device
	output logic psel_out = 1'b0,
	output logic penable_out = 1'b0,
	output logic pwrite_out = 1'b0,
	output logic [7:0] paddr_out = 8'h00,
	output logic [31:0] pwdata_out = 32'h0,
	output logic [3:0] pstrb_out = 4'h0,
	output logic select_n_out = 1'b1
);
	timeunit 1ns;
	timeprecision 1ps;
	// One transfer, held until pready is sampled high or 20 cycles pass
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic cs, output logic [31:0] q, output logic e, output bit ok);
		int n;
		@(posedge core_clk_in);
		psel_out <= 1'b1;
		pwrite_out <= w;
		paddr_out <= a;
		pwdata_out <= d;
		pstrb_out <= {4{w}};
		select_n_out <= !cs;
		@(posedge core_clk_in);
		penable_out <= 1'b1;
		n = 0;
		do
		begin
			@(posedge core_clk_in);
			n++;
		end
		while (pready_in !== 1'b1 && n < 20);
		ok = pready_in === 1'b1;
		q = prdata_in;
		e = pslverr_in;
		// Release: select idles high, data lines flip
		psel_out <= 1'b0;
		penable_out <= 1'b0;
		select_n_out <= 1'b1;
		paddr_out <= ~a;
		pwdata_out <= ~d;
	endtask
endmodule // tof_host_model

/* File: test/tof_result_readout_regs_tb_top.sv */
module tof_result_readout_regs_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic meas_valid_in = 1'b0;
	logic [1:0] meas_slot_in = 2'h0;
	logic [22:0] meas_fine_in = 23'h0;
	logic [15:0] meas_coarse_in = 16'h0;
	logic psel_in, penable_in, pwrite_in, channel_select_n_in, pready_out, pslverr_out;
	logic [7:0] paddr_in;
	logic [31:0] pwdata_in, prdata_out;
	logic [3:0] pstrb_in;
	logic [23:0] exp_w [6];
	int n_fail = 0;
	int compares = 0;
	integer seed = 32'hF2FC;
	////////////////////////////////////////
	tof_result_readout_regs dut_u (.*);
	tof_host_model host_u (
		.core_clk_in(core_clk_in),
		.pready_in(pready_out),
		.pslverr_in(pslverr_out),
		.prdata_in(prdata_out),
		.psel_out(psel_in),
		.penable_out(penable_in),
		.pwrite_out(pwrite_in),
		.paddr_out(paddr_in),
		.pwdata_out(pwdata_in),
		.pstrb_out(pstrb_in),
		.select_n_out(channel_select_n_in)
	);
	// Clock
	initial
	begin
		forever #5 core_clk_in = ~core_clk_in;
	end
	////////////////////////////////////////
	task automatic tally_and_finish();
		$display("Compares %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] want);
		compares++;
		if (seen !== want)
		begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, want, seen);
		end
	endtask
	// One access compared with the model
	task automatic acc(input logic w, input logic [7:0] a, input logic cs,
		input logic [31:0] want, input logic we);
		logic [31:0] q;
		logic e;
		bit ok;
		host_u.xfer(w, a, $random(seed), cs, q, e, ok);
		if (!ok)
		begin
			n_fail++;
			tally_and_finish();
		end
		else
		begin
			chk("prdata", q, want);
			chk("pslverr", {31'h0, e}, {31'h0, we});
		end
	endtask
	////////////////////////////////////////
	initial
	begin
		for (int i = 0; i < 6; i++)
			exp_w[i] = 24'h0;
		repeat (6) @(posedge core_clk_in);
		rst_in <= 1'b0;
		for (int k = 0; k < 5; k++)
		begin
			for (int i = 0; i < 6; i++)
				acc(1'b0, 8'h50 + 8'(4 * i), 1'b1, {8'h00, exp_w[i]}, 1'b0);
			acc(1'b0, 8'h68, 1'b1, 32'h0, 1'b1);
			acc(1'b0, 8'h52, 1'b1, 32'h0, 1'b1);
			acc(1'b0, 8'h54, 1'b0, 32'h0, 1'b1);
			acc(1'b1, 8'h50 + 8'(4 * (k % 6)), 1'b1, 32'h0, 1'b0);
			acc(1'b1, 8'h68, 1'b0, 32'h0, 1'b0);
			@(posedge core_clk_in);
			meas_valid_in <= 1'b1;
			meas_slot_in <= 2'(k);
			meas_fine_in <= 23'($random(seed));
			meas_coarse_in <= 16'($random(seed));
			@(posedge core_clk_in);
			meas_valid_in <= 1'b0;
			if (meas_slot_in < 2'h3)
			begin
				exp_w[2 * meas_slot_in] = {^meas_fine_in, meas_fine_in};
				exp_w[2 * meas_slot_in + 1] = {^meas_coarse_in, 7'h00, meas_coarse_in};
			end
			$display("Round %0d done", k);
		end
		// Mid-run reset clears every stored word
		@(posedge core_clk_in);
		rst_in <= 1'b1;
		repeat (2) @(posedge core_clk_in);
		rst_in <= 1'b0;
		for (int i = 0; i < 6; i++)
		begin
			exp_w[i] = 24'h0;
			acc(1'b0, 8'h50 + 8'(4 * i), 1'b1, {8'h00, exp_w[i]}, 1'b0);
		end
		$display("Reset test done");
		tally_and_finish();
	end
endmodule // tof_result_readout_regs_tb_top
